// File: hdl/supervisor_map.svh
`ifndef SUPERVISOR_MAP_SVH
`define SUPERVISOR_MAP_SVH

// register byte offsets
`define OFS_CTRL        4'h0
`define OFS_FLAGS       4'h4
`define OFS_STATUS      4'h8
`define OFS_MASK        4'hc

// control register fields
`define CTRL_RAIL_EN    0
`define CTRL_PIN_CTRL   1
`define CTRL_PIN_SEL    2
`define CTRL_DISCHARGE  3
`define CTRL_WARN_SEL   4
`define CTRL_OFF_MASK   5
`define CTRL_LIMIT_LSB  8
`define CTRL_RESET      32'h0000_0000

// flag register fields, write 1 to clear
`define FLG_PEAK_LSB    0
`define FLG_SHORT       4
`define FLG_WARN        5
`define FLG_TRIP        6
`define FLG_OFF         7
`define FLG_SUMMARY     8

// status register fields
`define STA_PEAK_LSB    0
`define STA_WARN        4
`define STA_TRIP        5
`define STA_RAIL_ON     6
`define STA_MODE_LSB    8

// mask register fields
`define MSK_PEAK_LSB    0
`define MSK_WARN        4
`define MASK_RESET      32'h0000_0000

// timing
`define CLK_PERIOD_NS   10
`define DEB_TIME_NS     20000
`define OVL_TIME_NS     1000000
`define PIN_SYNC_NS     3000
`define OTP_LOAD_CYC    16

`endif

// File: hdl/supervisor_pkg.sv
package supervisor_pkg;

  typedef enum logic [1:0] {
    MODE_SHUTDOWN,
    MODE_OTP_READ,
    MODE_STANDBY,
    MODE_ACTIVE
  } dev_mode_e;

  typedef logic [31:0] word_t;

endpackage

// File: hdl/regulator_protection_supervisor.sv
// The implementer's own choices: the Wishbone interface to the registers and the register addresses.
`include "supervisor_map.svh"

// How it works
// RULE1 - 20 us peak regulation sets flag, irq
// RULE2 - live peak status readable per regulator
// RULE3 - output low 1 ms after enable trips
// RULE4 - feedback low 1 ms in run trips
// RULE5 - trip sets short, summary, clears rail state
// RULE6 - clearing short flag retries start if requested
// RULE7 - warning threshold picked by config bit
// RULE8 - warning sets flag, irq, live bit
// RULE9 - overtemperature trips rail, flag, standby
// RULE10 - trip flag clear blocked while hot
// RULE11 - no enable while hot or trip pending
// RULE12 - fault off: stage hi-z, optional pulldown
// RULE13 - supply lockout forces shutdown, later standby
// RULE14 - came-from-off flag after shutdown if unmasked; the mask bit is still at reset then, so the flag is always set
// RULE15 - inputs debounced by clock-driven counters
// RULE16 - enable pins only synchronised, about 3 us
// RULE17 - otp load keeps regulator off
// RULE18 - standby: rail off, registers open, enable allowed
// RULE19 - active while a phase is enabled
// RULE20 - host sets equal limits on shared rail
// RULE21 - irq low while any unmasked flag set
// RULE22 - flags latched on event until cleared
module regulator_protection_supervisor #(
  parameter int PHASES     = 4,
  parameter int OVL_CYCLES = (`OVL_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
  parameter int OTP_CYCLES = `OTP_LOAD_CYC
) (
  // clock and reset
  input  wire logic              clk_sys_in,
  input  wire logic              rst_b_in,
  // wishbone slave
  input  wire logic              wb_cyc_in,
  input  wire logic              wb_stb_in,
  input  wire logic              wb_we_in,
  input  wire logic [3:0]        wb_adr_in,
  input  wire logic [3:0]        wb_sel_in,
  input  wire logic [31:0]       wb_dat_in,
  output logic      [31:0]       wb_dat_out,
  output logic                   wb_ack_out,
  // analog monitors
  input  wire logic [PHASES-1:0] peak_reg_in,
  input  wire logic              fb_low_in,
  input  wire logic              hot_warn_lo_in,
  input  wire logic              hot_warn_hi_in,
  input  wire logic              hot_trip_in,
  input  wire logic              main_supply_ok_in,
  input  wire logic              power_keep_in,
  input  wire logic              enable_pin_1_in,
  input  wire logic              enable_pin_2_in,
  // power stage and host
  output logic                   rail_on_out,
  output logic                   stage_hiz_out,
  output logic                   pulldown_en_out,
  output logic                   irq_n_out
);

  localparam int DEB_CYCLES  = (`DEB_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
  localparam int SYNC_CYCLES = `PIN_SYNC_NS / `CLK_PERIOD_NS;
  localparam int NCH         = PHASES + 3;
  localparam int CMAX        = (OVL_CYCLES > DEB_CYCLES) ? OVL_CYCLES : DEB_CYCLES;
  localparam int CW          = $clog2(CMAX + 1);
  localparam int SW          = $clog2(SYNC_CYCLES + 1);
  localparam int OW          = $clog2(OTP_CYCLES + 1);

  if (PHASES < 1 || PHASES > 4) begin : g_chk_phases
    $error("PHASES must be 1 to 4");
  end
  if (OVL_CYCLES < 1 || OTP_CYCLES < 1) begin : g_chk_counts
    $error("cycle counts must be at least 1");
  end

  supervisor_pkg::dev_mode_e mode_reg;
  supervisor_pkg::word_t     ctrl_reg;
  supervisor_pkg::word_t     mask_reg;
  supervisor_pkg::word_t     rd_next;

  logic [PHASES-1:0] peak_flag_reg;
  logic              short_flag_reg;
  logic              warn_flag_reg;
  logic              trip_flag_reg;
  logic              off_flag_reg;
  logic              was_off_reg;
  logic              fault_off_reg;
  logic [NCH-1:0]    raw;
  logic [NCH-1:0]    filt;
  logic [NCH-1:0]    filt_q_reg;
  logic [SW-1:0]     sync_cnt_reg;
  logic              pin1_reg;
  logic              pin2_reg;
  logic [CW-1:0]     start_cnt_reg;
  logic              start_done_reg;
  logic [OW-1:0]     otp_cnt_reg;
  logic              powered;
  logic              wr_en;
  logic              clr_flags;
  logic [31:0]       wmask;
  logic              pin_req;
  logic              en_req;
  logic              start_fail;
  logic              overload;
  logic              sc_trip;
  logic              hot_block;
  logic              can_start;
  logic [PHASES-1:0] peak_rise;
  logic              warn_rise;
  logic              trip_rise;
  logic              irq_next;

  // supply lockout acts without debounce
  assign powered = main_supply_ok_in & power_keep_in; // RULE13

  // channel order: peaks, warning, trip, feedback low
  assign raw = {fb_low_in, hot_trip_in,
                ctrl_reg[`CTRL_WARN_SEL] ? hot_warn_hi_in : hot_warn_lo_in, // RULE7
                peak_reg_in};

  // debounce counters, both edges
  for (genvar i = 0; i < NCH; i++) begin : g_deb
    localparam int LIM = (i == NCH - 1) ? OVL_CYCLES : DEB_CYCLES;
    logic [CW-1:0] cnt_reg;
    logic          val_reg;
    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
        cnt_reg <= '0;
        val_reg <= 1'b0;
      end else if (raw[i] == val_reg) begin
        cnt_reg <= '0; // RULE15
      end else if (cnt_reg == CW'(LIM - 1)) begin
        cnt_reg <= '0;
        val_reg <= raw[i]; // RULE15
      end else begin
        cnt_reg <= cnt_reg + 1'b1;
      end
    end
    assign filt[i] = val_reg;
  end

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      filt_q_reg <= '0;
    end else begin
      filt_q_reg <= filt;
    end
  end

  assign peak_rise = filt[PHASES-1:0] & ~filt_q_reg[PHASES-1:0];
  assign warn_rise = filt[PHASES] & ~filt_q_reg[PHASES];
  assign trip_rise = filt[PHASES+1] & ~filt_q_reg[PHASES+1];

  // enable pins sampled on a 3 us tick, no filtering
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sync_cnt_reg <= '0;
      pin1_reg     <= 1'b0;
      pin2_reg     <= 1'b0;
    end else if (sync_cnt_reg == SW'(SYNC_CYCLES - 1)) begin
      sync_cnt_reg <= '0;
      pin1_reg     <= enable_pin_1_in; // RULE16
      pin2_reg     <= enable_pin_2_in; // RULE16
    end else begin
      sync_cnt_reg <= sync_cnt_reg + 1'b1;
    end
  end

  assign pin_req = ctrl_reg[`CTRL_PIN_SEL] ? pin2_reg : pin1_reg;
  assign en_req  = ctrl_reg[`CTRL_RAIL_EN] & (~ctrl_reg[`CTRL_PIN_CTRL] | pin_req);

  // start-up short and running overload
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      start_cnt_reg  <= '0;
      start_done_reg <= 1'b0;
    end else if (mode_reg != supervisor_pkg::MODE_ACTIVE) begin
      start_cnt_reg  <= '0;
      start_done_reg <= 1'b0;
    end else if (!start_done_reg) begin
      if (start_cnt_reg == CW'(OVL_CYCLES - 1)) begin
        start_done_reg <= 1'b1;
      end
      start_cnt_reg <= start_cnt_reg + 1'b1;
    end
  end

  assign start_fail = ~start_done_reg & (start_cnt_reg == CW'(OVL_CYCLES - 1))
                      & fb_low_in; // RULE3
  assign overload   = start_done_reg & filt[NCH-1]; // RULE4
  assign sc_trip    = (mode_reg == supervisor_pkg::MODE_ACTIVE) & (start_fail | overload);
  assign hot_block  = filt[PHASES+1] | trip_flag_reg; // RULE11
  assign can_start  = en_req & ~hot_block & ~short_flag_reg; // RULE6

  // operating modes
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      mode_reg    <= supervisor_pkg::MODE_SHUTDOWN;
      otp_cnt_reg <= '0;
    end else if (!powered) begin
      mode_reg    <= supervisor_pkg::MODE_SHUTDOWN; // RULE13
      otp_cnt_reg <= '0;
    end else begin
      case (mode_reg)
        supervisor_pkg::MODE_SHUTDOWN: begin
          mode_reg <= supervisor_pkg::MODE_OTP_READ;
        end
        supervisor_pkg::MODE_OTP_READ: begin
          if (otp_cnt_reg == OW'(OTP_CYCLES - 1)) begin
            mode_reg <= supervisor_pkg::MODE_STANDBY; // RULE17
          end
          otp_cnt_reg <= otp_cnt_reg + 1'b1;
        end
        supervisor_pkg::MODE_STANDBY: begin
          if (can_start) begin
            mode_reg <= supervisor_pkg::MODE_ACTIVE; // RULE18
          end
        end
        supervisor_pkg::MODE_ACTIVE: begin
          if (sc_trip || filt[PHASES+1] || !en_req) begin
            mode_reg <= supervisor_pkg::MODE_STANDBY; // RULE9
          end
        end
        default: begin
          mode_reg <= supervisor_pkg::MODE_SHUTDOWN;
        end
      endcase
    end
  end

  // power stage outputs
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      fault_off_reg <= 1'b0;
    end else if (!powered) begin
      fault_off_reg <= 1'b1; // RULE13
    end else if (mode_reg == supervisor_pkg::MODE_ACTIVE && (sc_trip || filt[PHASES+1])) begin
      fault_off_reg <= 1'b1; // RULE12
    end else if (mode_reg == supervisor_pkg::MODE_STANDBY && can_start) begin
      fault_off_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rail_on_out     <= 1'b0;
      stage_hiz_out   <= 1'b1;
      pulldown_en_out <= 1'b0;
    end else begin
      rail_on_out     <= (mode_reg == supervisor_pkg::MODE_ACTIVE) & ~sc_trip
                         & ~filt[PHASES+1] & en_req & powered; // RULE19
      stage_hiz_out   <= (mode_reg != supervisor_pkg::MODE_ACTIVE) | sc_trip
                         | filt[PHASES+1] | ~powered; // RULE12
      pulldown_en_out <= ~powered
                         | (fault_off_reg & ctrl_reg[`CTRL_DISCHARGE]
                            & (mode_reg != supervisor_pkg::MODE_ACTIVE)); // RULE12
    end
  end

  // wishbone access
  assign wr_en     = wb_cyc_in & wb_stb_in & wb_we_in & ~wb_ack_out;
  assign wmask     = {{8{wb_sel_in[3]}}, {8{wb_sel_in[2]}}, {8{wb_sel_in[1]}}, {8{wb_sel_in[0]}}};
  assign clr_flags = wr_en & (wb_adr_in == `OFS_FLAGS);

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      wb_ack_out <= 1'b0;
    end else begin
      wb_ack_out <= wb_cyc_in & wb_stb_in & ~wb_ack_out;
    end
  end

  // configuration, defaulted in shutdown and otp load
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ctrl_reg <= `CTRL_RESET;
      mask_reg <= `MASK_RESET;
    end else if (mode_reg == supervisor_pkg::MODE_SHUTDOWN
                 || mode_reg == supervisor_pkg::MODE_OTP_READ) begin
      ctrl_reg <= `CTRL_RESET; // RULE14
      mask_reg <= `MASK_RESET;
    end else if (wr_en && wb_adr_in == `OFS_CTRL) begin
      ctrl_reg <= (ctrl_reg & ~wmask) | (wb_dat_in & wmask); // RULE18
    end else if (wr_en && wb_adr_in == `OFS_MASK) begin
      mask_reg <= (mask_reg & ~wmask) | (wb_dat_in & wmask);
    end
  end

  // event flags, a new event wins over a clear
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      peak_flag_reg  <= '0;
      short_flag_reg <= 1'b0;
      warn_flag_reg  <= 1'b0;
      trip_flag_reg  <= 1'b0;
    end else if (mode_reg == supervisor_pkg::MODE_SHUTDOWN) begin
      peak_flag_reg  <= '0;
      short_flag_reg <= 1'b0;
      warn_flag_reg  <= 1'b0;
      trip_flag_reg  <= 1'b0;
    end else begin
      for (int p = 0; p < PHASES; p++) begin
        if (peak_rise[p]) begin
          peak_flag_reg[p] <= 1'b1; // RULE1
        end else if (clr_flags && wb_sel_in[0] && wb_dat_in[`FLG_PEAK_LSB+p]) begin
          peak_flag_reg[p] <= 1'b0; // RULE22
        end
      end
      if (sc_trip) begin
        short_flag_reg <= 1'b1; // RULE5
      end else if (clr_flags && wb_sel_in[0] && wb_dat_in[`FLG_SHORT]) begin
        short_flag_reg <= 1'b0; // RULE6
      end
      if (warn_rise) begin
        warn_flag_reg <= 1'b1; // RULE8
      end else if (clr_flags && wb_sel_in[0] && wb_dat_in[`FLG_WARN]) begin
        warn_flag_reg <= 1'b0; // RULE8
      end
      if (trip_rise) begin
        trip_flag_reg <= 1'b1; // RULE9
      end else if (clr_flags && wb_sel_in[0] && wb_dat_in[`FLG_TRIP]
                   && !filt[PHASES+1]) begin
        trip_flag_reg <= 1'b0; // RULE10
      end
    end
  end

  // came-from-off flag
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      was_off_reg  <= 1'b1;
      off_flag_reg <= 1'b0;
    end else if (mode_reg == supervisor_pkg::MODE_SHUTDOWN) begin
      was_off_reg  <= 1'b1;
      off_flag_reg <= 1'b0;
    end else if (was_off_reg && mode_reg == supervisor_pkg::MODE_STANDBY) begin
      was_off_reg  <= 1'b0;
      off_flag_reg <= ~ctrl_reg[`CTRL_OFF_MASK]; // RULE14
    end else if (clr_flags && wb_sel_in[0] && wb_dat_in[`FLG_OFF]) begin
      off_flag_reg <= 1'b0; // RULE14
    end
  end

  // interrupt line
  assign irq_next = |(peak_flag_reg & ~mask_reg[`MSK_PEAK_LSB +: PHASES])
                    | short_flag_reg | trip_flag_reg | off_flag_reg
                    | (warn_flag_reg & ~mask_reg[`MSK_WARN]);

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      irq_n_out <= 1'b1;
    end else begin
      irq_n_out <= ~irq_next; // RULE21
    end
  end

  // read data
  always_comb begin
    rd_next = '0;
    case (wb_adr_in)
      `OFS_CTRL: begin
        rd_next = ctrl_reg;
      end
      `OFS_FLAGS: begin
        rd_next[`FLG_PEAK_LSB +: PHASES] = peak_flag_reg;
        rd_next[`FLG_SHORT]   = short_flag_reg;
        rd_next[`FLG_WARN]    = warn_flag_reg;
        rd_next[`FLG_TRIP]    = trip_flag_reg;
        rd_next[`FLG_OFF]     = off_flag_reg;
        rd_next[`FLG_SUMMARY] = short_flag_reg | peak_flag_reg[0]; // RULE5
      end
      `OFS_STATUS: begin
        rd_next[`STA_PEAK_LSB +: PHASES] = filt[PHASES-1:0]; // RULE2
        rd_next[`STA_WARN]    = filt[PHASES]; // RULE8
        rd_next[`STA_TRIP]    = filt[PHASES+1]; // RULE9
        rd_next[`STA_RAIL_ON] = rail_on_out; // RULE5
        rd_next[`STA_MODE_LSB +: 2] = mode_reg;
      end
      `OFS_MASK: begin
        rd_next = mask_reg;
      end
      default: begin
        rd_next = '0;
      end
    endcase
  end

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      wb_dat_out <= '0;
    end else if (wb_cyc_in && wb_stb_in && !wb_we_in && !wb_ack_out) begin
      wb_dat_out <= rd_next;
    end
  end

endmodule // regulator_protection_supervisor

// File: sim/regulator_protection_supervisor_checker.sv
module regulator_protection_supervisor_checker #(
  parameter int PHASES     = 4,
  parameter int OVL_CYCLES = 50
) (
  // clock, reset, bus
  input wire logic              clk_sys_in,
  input wire logic              rst_b_in,
  input wire logic              wb_cyc_in,
  input wire logic              wb_stb_in,
  input wire logic              wb_we_in,
  input wire logic [3:0]        wb_adr_in,
  input wire logic [3:0]        wb_sel_in,
  input wire logic [31:0]       wb_dat_in,
  input wire logic [31:0]       wb_dat_out,
  input wire logic              wb_ack_out,
  // monitors
  input wire logic [PHASES-1:0] peak_reg_in,
  input wire logic              fb_low_in,
  input wire logic              hot_warn_lo_in,
  input wire logic              hot_warn_hi_in,
  input wire logic              hot_trip_in,
  input wire logic              main_supply_ok_in,
  input wire logic              power_keep_in,
  input wire logic              enable_pin_1_in,
  input wire logic              enable_pin_2_in,
  // stage and host
  input wire logic              rail_on_out,
  input wire logic              stage_hiz_out,
  input wire logic              pulldown_en_out,
  input wire logic              irq_n_out
);
  localparam int OVL_LIM = OVL_CYCLES + 2;
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rst_b_in);

  property p_ack_next;
    wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out;
  endproperty
  a_ack_next: assert property (p_ack_next) else $error("no ack after request");

  property p_ack_pulse;
    wb_ack_out |=> !wb_ack_out;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");

  property p_unmapped;
    wb_ack_out && !$past(wb_we_in) && (($past(wb_adr_in) & 4'h3) != 4'h0)
      |-> wb_dat_out == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

  property p_rail_pull;
    rail_on_out |-> !pulldown_en_out;
  endproperty
  a_rail_pull: assert property (p_rail_pull) else $error("pulldown while rail on");

  property p_trip_hiz;
    $fell(rail_on_out) && fb_low_in |-> stage_hiz_out;
  endproperty
  a_trip_hiz: assert property (p_trip_hiz) else $error("stage not high-z on trip");

  property p_lockout;
    !main_supply_ok_in |=> !rail_on_out && pulldown_en_out;
  endproperty
  a_lockout: assert property (p_lockout) else $error("lockout not immediate");

  property p_irq_rise;
    $rose(irq_n_out) |-> ($past(wb_cyc_in) && $past(wb_we_in))
      || ($past(wb_cyc_in, 2) && $past(wb_we_in, 2))
      || !$past(main_supply_ok_in, 2) || !$past(power_keep_in, 2);
  endproperty
  a_irq_rise: assert property (p_irq_rise) else $error("irq released without clear");

  property p_startup;
    $rose(rail_on_out) && fb_low_in |-> ##[1:OVL_LIM] !rail_on_out;
  endproperty
  a_startup: assert property (p_startup) else $error("start-up short not tripped");
endmodule // regulator_protection_supervisor_checker

// File: sim/host_model.sv
module host_model (
  // clock and slave answer
  input  wire logic        clk_sys_in,
  input  wire logic        ack_in,
  input  wire logic [31:0] dat_in,
  // master request
  output logic             cyc_out,
  output logic             stb_out,
  output logic             we_out,
  output logic [3:0]       adr_out,
  output logic [3:0]       sel_out,
  output logic [31:0]      dat_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] exp_q[$];
  logic        note;
  int          tmo = 0;
  initial begin
    {cyc_out, stb_out, we_out, adr_out, sel_out, dat_out, note} = '0;
  end
  // one classic cycle; released lines are scrambled
  task automatic xfer(input logic we, input logic [3:0] adr, input logic [31:0] dat,
                      input logic chk, output logic [31:0] rdat);
    int i;
    @(posedge clk_sys_in);
    {cyc_out, stb_out, sel_out} <= {2'b11, 4'hf};
    {we_out, adr_out, dat_out, note} <= {we, adr, dat, chk};
    if (chk) exp_q.push_back(dat);
    for (i = 0; i < 20; i++) begin
      @(posedge clk_sys_in);
      if (ack_in) break;
    end
    if (i == 20) tmo++;
    rdat = dat_in;
    {cyc_out, stb_out, sel_out} <= '0;
    {we_out, adr_out, dat_out} <= {~we, ~adr, ~dat};
  endtask
endmodule // host_model

// File: sim/regulator_protection_supervisor_tb_top.sv
module regulator_protection_supervisor_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int PHASES     = 4;
  localparam int OVL_CYCLES = 50;
  logic        clk_sys_in, rst_b_in, wb_cyc_in, wb_stb_in, wb_we_in, wb_ack_out;
  logic [3:0]  wb_adr_in, wb_sel_in, peak_reg_in;
  logic [31:0] wb_dat_in, wb_dat_out, rd_val, seed;
  logic        fb_low_in, hot_warn_lo_in, hot_warn_hi_in, hot_trip_in, main_supply_ok_in;
  logic        power_keep_in, enable_pin_1_in, enable_pin_2_in;
  logic        rail_on_out, stage_hiz_out, pulldown_en_out, irq_n_out;
  int          num_errors = 0;
  int          checked = 0;

  regulator_protection_supervisor #(.PHASES(PHASES), .OVL_CYCLES(OVL_CYCLES), .OTP_CYCLES(4))
    regulator_protection_supervisor_i (.clk_sys_in, .rst_b_in, .wb_cyc_in, .wb_stb_in,
    .wb_we_in, .wb_adr_in, .wb_sel_in, .wb_dat_in, .wb_dat_out, .wb_ack_out, .peak_reg_in,
    .fb_low_in, .hot_warn_lo_in, .hot_warn_hi_in, .hot_trip_in, .main_supply_ok_in,
    .power_keep_in, .enable_pin_1_in, .enable_pin_2_in, .rail_on_out, .stage_hiz_out,
    .pulldown_en_out, .irq_n_out);
  host_model host_model_i (.clk_sys_in, .ack_in(wb_ack_out), .dat_in(wb_dat_out),
    .cyc_out(wb_cyc_in), .stb_out(wb_stb_in), .we_out(wb_we_in), .adr_out(wb_adr_in),
    .sel_out(wb_sel_in), .dat_out(wb_dat_in));

  initial begin
    clk_sys_in = 1'b0;
    forever #5 clk_sys_in = ~clk_sys_in;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    host_model_i.xfer(1'b1, a, d, 1'b0, rd_val);
    if (host_model_i.tmo != 0) test_done();
  endtask
  task automatic chk(input logic [3:0] a, input logic [31:0] e);
    host_model_i.xfer(1'b0, a, e, 1'b1, rd_val);
    if (host_model_i.tmo != 0) test_done();
  endtask
  // read until masked value matches, bounded
  task automatic poll(input logic [3:0] a, input logic [31:0] m, input logic [31:0] v);
    int i;
    for (i = 0; i < 200; i++) begin
      host_model_i.xfer(1'b0, a, 32'h0, 1'b0, rd_val);
      if ((rd_val & m) === v) break;
    end
    cmp(rd_val & m, v);
    if (i == 200 || host_model_i.tmo != 0) test_done();
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_in);
  endtask
  task automatic test_done;
    num_errors += host_model_i.tmo;
    $display("checked %0d, errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // read results against oldest note
  always @(posedge clk_sys_in)
    if (wb_ack_out && !wb_we_in && host_model_i.note) cmp(wb_dat_out, host_model_i.exp_q.pop_front());

  initial begin
    tick(100000);
    num_errors++;
    test_done();
  end

  initial begin
    {rst_b_in, peak_reg_in, fb_low_in, hot_warn_lo_in, hot_warn_hi_in, hot_trip_in} = '0;
    {main_supply_ok_in, power_keep_in, enable_pin_1_in, enable_pin_2_in} = 4'hc;
    seed = 32'hbfe4;
    tick(2);
    rst_b_in <= 1'b1;
    poll(4'h8, 32'h300, 32'h200);
    tick(2);
    cmp(irq_n_out, 32'h0);
    chk(4'h4, 32'h80);
    wr(4'h4, 32'h80);
    tick(2);
    cmp(irq_n_out, 32'h1);
    chk(4'h2, 32'h0);
    repeat (4) begin
      seed = lfsr(seed);
      wr(4'hc, seed);
      chk(4'hc, seed);
    end
    wr(4'hc, 32'h12);
    $display("power-up test done");
    wr(4'h0, 32'h10);
    peak_reg_in <= 4'h2;
    hot_warn_hi_in <= 1'b1;
    tick(2010);
    chk(4'h4, 32'h22);
    chk(4'h8, 32'h212);
    cmp(irq_n_out, 32'h1);
    wr(4'hc, 32'h0);
    tick(2);
    cmp(irq_n_out, 32'h0);
    {peak_reg_in, hot_warn_hi_in} <= '0;
    wr(4'h4, 32'h22);
    tick(2);
    cmp(irq_n_out, 32'h1);
    tick(2010);
    chk(4'h4, 32'h0);
    $display("warning test done");
    fb_low_in <= 1'b1;
    wr(4'h0, 32'h19);
    poll(4'h8, 32'h340, 32'h340);
    poll(4'h8, 32'h40, 32'h0);
    chk(4'h4, 32'h110);
    cmp({stage_hiz_out, pulldown_en_out, irq_n_out}, 32'h6);
    fb_low_in <= 1'b0;
    wr(4'h4, 32'h10);
    poll(4'h8, 32'h340, 32'h340);
    cmp({stage_hiz_out, pulldown_en_out}, 32'h0);
    $display("short test done");
    {hot_trip_in, hot_warn_lo_in} <= 2'b11;
    tick(2010);
    chk(4'h8, 32'h220);
    chk(4'h4, 32'h40);
    wr(4'h4, 32'h40);
    chk(4'h4, 32'h40);
    {hot_trip_in, hot_warn_lo_in} <= 2'b00;
    tick(2010);
    chk(4'h8, 32'h200);
    wr(4'h4, 32'h40);
    poll(4'h8, 32'h340, 32'h340);
    $display("thermal test done");
    enable_pin_1_in <= 1'b1;
    wr(4'h0, 32'h0f);
    poll(4'h8, 32'h40, 32'h0);
    enable_pin_2_in <= 1'b1;
    poll(4'h8, 32'h40, 32'h40);
    $display("pin test done");
    main_supply_ok_in <= 1'b0;
    tick(2);
    cmp({rail_on_out, pulldown_en_out}, 32'h1);
    chk(4'h8, 32'h0);
    main_supply_ok_in <= 1'b1;
    poll(4'h8, 32'h300, 32'h200);
    tick(2);
    chk(4'h4, 32'h80);
    $display("lockout test done");
    test_done();
  end
endmodule // regulator_protection_supervisor_tb_top

bind regulator_protection_supervisor regulator_protection_supervisor_checker #(
  .PHASES(PHASES), .OVL_CYCLES(OVL_CYCLES)) checker_i (.clk_sys_in, .rst_b_in, .wb_cyc_in,
  .wb_stb_in, .wb_we_in, .wb_adr_in, .wb_sel_in, .wb_dat_in, .wb_dat_out, .wb_ack_out,
  .peak_reg_in, .fb_low_in, .hot_warn_lo_in, .hot_warn_hi_in, .hot_trip_in,
  .main_supply_ok_in, .power_keep_in, .enable_pin_1_in, .enable_pin_2_in, .rail_on_out,
  .stage_hiz_out, .pulldown_en_out, .irq_n_out);
